//--- src/tmc_pkg.sv
// package: register map, fields, types and timing constants of the timer core
package tmc_pkg;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [5:0] ADDR_CTRL0 = 6'h00;
	localparam logic [5:0] ADDR_CTRL1 = 6'h04;
	localparam logic [5:0] ADDR_CNT_LO = 6'h08;
	localparam logic [5:0] ADDR_CNT_HI = 6'h0C;
	localparam logic [5:0] ADDR_CMPA_LO = 6'h10;
	localparam logic [5:0] ADDR_CMPA_HI = 6'h14;
	localparam logic [5:0] ADDR_CMPP_LO = 6'h18;
	localparam logic [5:0] ADDR_CMPP_HI = 6'h1C;
	localparam logic [5:0] ADDR_IRQ_STAT = 6'h20;
	localparam logic [5:0] ADDR_IRQ_EN = 6'h24;
	localparam logic [5:0] ADDR_IRQ_CLR = 6'h28;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL0_PAUSE = 7;
	localparam int CTRL0_CKSEL_LSB = 4;
	localparam int CTRL0_ON = 3;
	localparam int CTRL1_MODE_LSB = 6;
	localparam int CTRL1_OFUNC_LSB = 4;
	localparam int CTRL1_INIT = 3;
	localparam int CTRL1_PCLR = 0;
	localparam int IRQ_A = 0;
	localparam int IRQ_P = 1;
	localparam int IRQ_OVF = 2;

	localparam logic [7:0] CTRL0_MASK = 8'hF8;
	localparam logic [7:0] CTRL1_MASK = 8'hF9;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [2:0] IRQ_ZERO = 3'h0;

	// ----------------------------------------
	// clock select codes and dividers
	// ----------------------------------------
	localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_HIGH_DIV16 = 3'h2;
	localparam logic [2:0] CK_HIGH_DIV64 = 3'h3;
	localparam logic [2:0] CK_SUB_A = 3'h4;
	localparam logic [2:0] CK_SUB_B = 3'h5;
	localparam logic [2:0] CK_EXT_RISE = 3'h6;
	localparam logic [2:0] CK_EXT_FALL = 3'h7;
	localparam logic [5:0] DIV4_LAST = 6'h03;
	localparam logic [5:0] DIV16_LAST = 6'h0F;
	localparam logic [5:0] DIV64_LAST = 6'h3F;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_CMP_OUT,
		MODE_UNDEF,
		MODE_PWM,
		MODE_TIMER
	} tmc_mode_t;

	typedef enum logic [1:0] {
		OF_NONE,
		OF_LOW,
		OF_HIGH,
		OF_TOGGLE
	} tmc_ofunc_t;

	typedef struct packed {
		logic pause;
		logic [2:0] clk_sel;
		logic on;
	} tmc_ctrl0_t;

	typedef struct packed {
		tmc_mode_t mode;
		tmc_ofunc_t ofunc;
		logic init_level;
		logic p_clears;
	} tmc_ctrl1_t;

endpackage

//--- src/tmc_ext_edge.sv
// external input synchroniser and selected-edge detector
`timescale 1ns/10ps
`default_nettype none
module tmc_ext_edge
	import tmc_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pin and edge choice
	input wire logic pin_in,
	input wire logic fall_sel,
	// pulses
	output logic rise_pulse,
	output logic fall_pulse,
	output logic sel_pulse
);
	logic [2:0] sync_reg;
	logic [2:0] sync_next;

	always_comb begin
		sync_next = {sync_reg[1:0], pin_in};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_reg <= 3'h0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	// stage 0 feeds only stage 1; edges compare stages 1 and 2
	assign rise_pulse = sync_reg[1] & ~sync_reg[2];
	assign fall_pulse = ~sync_reg[1] & sync_reg[2];
	assign sel_pulse = fall_sel ? fall_pulse : rise_pulse;
endmodule
`default_nettype wire

//--- src/tmc_core.sv
// timer module common core with axi4-lite register slave
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - free-running counter compared with both comparators
// - match raises interrupt, may clear, drive output
// - separate interrupt sources for comparators A, P
// - three-bit select picks counter clock source
// - external pin counts rising or falling edge
// - external pin triggers single pulse output
// - compare output sets high, low, or toggles
// - pwm appears on the same output pin
// - edge-aligned pwm, duty or period adjustable
// - high byte direct, low byte via buffer
// - compare low write loads buffer only
// - compare high write also copies buffer low
// - high-byte read captures low byte into buffer
// - low-byte read returns buffer contents
// - counter is sixteen bits, counting upward
// - overflow or selected match (P if p_clears, else A) clears counter, raises interrupt
module tmc_core
	import tmc_pkg::*;
#(
	parameter int CNT_W = 16
)(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// clock sources as enables
	input wire logic high_clk_en,
	input wire logic sub_clk_en,
	// pins
	input wire logic timer_ext_clock_in,
	output logic timer_wave_out,
	output logic timer_wave_oe,
	output logic pulse_trigger,
	// interrupt
	output logic irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	tmc_ctrl0_t ctrl0_reg, ctrl0_next;
	tmc_ctrl1_t ctrl1_reg, ctrl1_next;
	logic [CNT_W-1:0] count_reg, count_next;
	logic [15:0] compare_a_value_reg, compare_a_value_next;
	logic [15:0] compare_p_value_reg, compare_p_value_next;
	logic [7:0] hold_reg, hold_next;
	logic [2:0] irq_stat_reg, irq_stat_next;
	logic [2:0] irq_en_reg, irq_en_next;
	logic wave_reg, wave_next;
	logic [5:0] div_sys_reg, div_sys_next;
	logic [5:0] div_high_reg, div_high_next;
	logic aw_got_reg, aw_got_next;
	logic w_got_reg, w_got_next;
	logic [5:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;

	logic ext_rise, ext_fall, ext_sel;
	logic tick, on_rise, match_a, match_p, ovf;
	logic wr_fire, rd_fire, wr_lane0;
	logic [7:0] wbyte;

	// ----------------------------------------
	// external pin
	// ----------------------------------------
	tmc_ext_edge u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(timer_ext_clock_in),
		.fall_sel(ctrl0_reg.clk_sel == CK_EXT_FALL),
		.rise_pulse(ext_rise),
		.fall_pulse(ext_fall),
		.sel_pulse(ext_sel)
	);

	assign pulse_trigger = ext_sel;

	// ----------------------------------------
	// clock select
	// ----------------------------------------
	always_comb begin
		div_sys_next = (div_sys_reg == DIV4_LAST) ? 6'h00 : div_sys_reg + 6'h01;
		div_high_next = div_high_reg;
		if (high_clk_en) begin
			div_high_next = div_high_reg + 6'h01;
		end
		unique case (ctrl0_reg.clk_sel)
			CK_SYS_DIV4: tick = div_sys_reg == DIV4_LAST;
			CK_SYS: tick = 1'b1;
			CK_HIGH_DIV16: tick = high_clk_en && div_high_reg[3:0] == DIV16_LAST[3:0];
			CK_HIGH_DIV64: tick = high_clk_en && div_high_reg == DIV64_LAST;
			CK_SUB_A, CK_SUB_B: tick = sub_clk_en;
			default: tick = ext_sel;
		endcase
	end

	// ----------------------------------------
	// counter, comparators, output
	// ----------------------------------------
	assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_lane0 = w_strb_reg[0];
	assign wbyte = w_data_reg[7:0];
	assign on_rise = wr_fire && wr_lane0 && aw_addr_reg == ADDR_CTRL0
		&& wbyte[CTRL0_ON] && !ctrl0_reg.on;
	assign match_a = count_reg == compare_a_value_reg;
	assign match_p = count_reg[15:8] == compare_p_value_reg[15:8];
	assign ovf = count_reg == CNT_MAX;

	always_comb begin
		count_next = count_reg;
		wave_next = wave_reg;
		if (on_rise) begin
			count_next = CNT_ZERO;
			wave_next = ctrl1_reg.init_level;
		end else if (ctrl0_reg.on && !ctrl0_reg.pause && tick) begin
			if ((ctrl1_reg.p_clears && match_p) || (!ctrl1_reg.p_clears && match_a) || ovf) begin
				count_next = CNT_ZERO;
			end else begin
				count_next = count_reg + CNT_ONE;
			end
			if (ctrl1_reg.mode == MODE_CMP_OUT && match_a) begin
				unique case (ctrl1_reg.ofunc)
					OF_NONE: wave_next = wave_reg;
					OF_LOW: wave_next = 1'b0;
					OF_HIGH: wave_next = 1'b1;
					OF_TOGGLE: wave_next = ~wave_reg;
				endcase
			end
		end
		if (ctrl1_reg.mode == MODE_PWM) begin
			// edge-aligned: active from period start to duty match
			unique case (ctrl1_reg.ofunc)
				OF_NONE: wave_next = ~ctrl1_reg.init_level;
				OF_LOW: wave_next = ctrl1_reg.init_level;
				OF_HIGH: wave_next = ctrl1_reg.init_level ^ ~(ctrl1_reg.p_clears
					? count_reg < compare_a_value_reg
					: count_reg[15:8] < compare_p_value_reg[15:8]);
				OF_TOGGLE: wave_next = wave_reg;
			endcase
		end
	end

	assign timer_wave_out = wave_reg;
	assign timer_wave_oe = ctrl0_reg.on && ctrl1_reg.mode != MODE_TIMER;

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_comb begin
		irq_stat_next = irq_stat_reg;
		irq_en_next = irq_en_reg;
		if (wr_fire && wr_lane0 && aw_addr_reg == ADDR_IRQ_CLR) begin
			irq_stat_next = irq_stat_reg & ~wbyte[2:0];
		end
		if (wr_fire && wr_lane0 && aw_addr_reg == ADDR_IRQ_EN) begin
			irq_en_next = wbyte[2:0];
		end
		// set wins over clear
		if (ctrl0_reg.on && !ctrl0_reg.pause && tick) begin
			irq_stat_next[IRQ_A] = irq_stat_next[IRQ_A] | match_a;
			irq_stat_next[IRQ_P] = irq_stat_next[IRQ_P] | match_p;
			irq_stat_next[IRQ_OVF] = irq_stat_next[IRQ_OVF] | ovf;
		end
	end

	assign irq = |(irq_stat_reg & irq_en_reg);

	// ----------------------------------------
	// register writes and byte buffer
	// ----------------------------------------
	always_comb begin
		ctrl0_next = ctrl0_reg;
		ctrl1_next = ctrl1_reg;
		compare_a_value_next = compare_a_value_reg;
		compare_p_value_next = compare_p_value_reg;
		hold_next = hold_reg;
		if (wr_fire && wr_lane0) begin
			unique case (aw_addr_reg)
				ADDR_CTRL0: ctrl0_next = tmc_ctrl0_t'(wbyte[7:3]);
				ADDR_CTRL1: ctrl1_next = tmc_ctrl1_t'({wbyte[7:3], wbyte[CTRL1_PCLR]});
				ADDR_CMPA_LO, ADDR_CMPP_LO: hold_next = wbyte;
				ADDR_CMPA_HI: compare_a_value_next = {wbyte, hold_reg};
				ADDR_CMPP_HI: compare_p_value_next = {wbyte, hold_reg};
				default: hold_next = hold_reg;
			endcase
		end
		if (rd_fire) begin
			unique case (s_axi_araddr)
				ADDR_CNT_HI: hold_next = count_reg[7:0];
				ADDR_CMPA_HI: hold_next = compare_a_value_reg[7:0];
				ADDR_CMPP_HI: hold_next = compare_p_value_reg[7:0];
				default: hold_next = hold_next;
			endcase
		end
	end

	// ----------------------------------------
	// axi4-lite handshakes
	// ----------------------------------------
	assign s_axi_awready = !aw_got_reg;
	assign s_axi_wready = !w_got_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	function automatic logic mapped(input logic [5:0] a);
		mapped = a <= ADDR_IRQ_CLR && a[1:0] == 2'h0;
	endfunction

	always_comb begin
		aw_got_next = aw_got_reg;
		w_got_next = w_got_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid && !aw_got_reg) begin
			aw_got_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_got_reg) begin
			w_got_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (wr_fire) begin
			bvalid_next = 1'b1;
			bresp_next = mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
		end
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				ADDR_CTRL0: rdata_next = {24'h0, ctrl0_reg, 3'h0};
				ADDR_CTRL1: rdata_next = {24'h0, ctrl1_reg[5:1], 2'h0, ctrl1_reg[0]};
				ADDR_CNT_HI: rdata_next = {24'h0, count_reg[15:8]};
				ADDR_CMPA_HI: rdata_next = {24'h0, compare_a_value_reg[15:8]};
				ADDR_CMPP_HI: rdata_next = {24'h0, compare_p_value_reg[15:8]};
				ADDR_CNT_LO, ADDR_CMPA_LO, ADDR_CMPP_LO: rdata_next = {24'h0, hold_reg};
				ADDR_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
				ADDR_IRQ_EN: rdata_next = {29'h0, irq_en_reg};
				default: rdata_next = 32'h0;
			endcase
		end else if (s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl0_reg <= '0;
			ctrl1_reg <= '0;
			count_reg <= CNT_ZERO;
			compare_a_value_reg <= CNT_ZERO;
			compare_p_value_reg <= CNT_ZERO;
			hold_reg <= BYTE_ZERO;
			irq_stat_reg <= IRQ_ZERO;
			irq_en_reg <= IRQ_ZERO;
			wave_reg <= 1'b0;
			div_sys_reg <= 6'h00;
			div_high_reg <= 6'h00;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 6'h00;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= RESP_OKAY;
		end else begin
			ctrl0_reg <= ctrl0_next;
			ctrl1_reg <= ctrl1_next;
			count_reg <= count_next;
			compare_a_value_reg <= compare_a_value_next;
			compare_p_value_reg <= compare_p_value_next;
			hold_reg <= hold_next;
			irq_stat_reg <= irq_stat_next;
			irq_en_reg <= irq_en_next;
			wave_reg <= wave_next;
			div_sys_reg <= div_sys_next;
			div_high_reg <= div_high_next;
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic running;
	assign running = ctrl0_reg.on && !ctrl0_reg.pause && !on_rise;

	property p_count_up;
		@(posedge aclk) disable iff (!aresetn)
		running && tick && !ovf && !match_a && !match_p |=> count_reg == $past(count_reg) + CNT_ONE;
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter did not step");

	property p_ovf_clear;
		@(posedge aclk) disable iff (!aresetn)
		running && tick && ovf |=> count_reg == CNT_ZERO && irq_stat_reg[IRQ_OVF];
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow did not clear");

	property p_match_a_irq;
		@(posedge aclk) disable iff (!aresetn)
		running && tick && match_a |=> irq_stat_reg[IRQ_A];
	endproperty
	a_match_a_irq: assert property (p_match_a_irq) else $error("match a flag missing");

	property p_match_p_irq;
		@(posedge aclk) disable iff (!aresetn)
		running && tick && match_p |=> irq_stat_reg[IRQ_P];
	endproperty
	a_match_p_irq: assert property (p_match_p_irq) else $error("match p flag missing");

	property p_irq_sticky;
		@(posedge aclk) disable iff (!aresetn)
		irq_stat_reg[IRQ_A] && !(wr_fire && wr_lane0 && aw_addr_reg == ADDR_IRQ_CLR && wbyte[IRQ_A])
			|=> irq_stat_reg[IRQ_A];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("match a flag lost");

	property p_low_write_buffer;
		@(posedge aclk) disable iff (!aresetn)
		wr_fire && wr_lane0 && aw_addr_reg == ADDR_CMPA_LO
			|=> compare_a_value_reg == $past(compare_a_value_reg) && hold_reg == $past(wbyte);
	endproperty
	a_low_write_buffer: assert property (p_low_write_buffer) else $error("low write hit compare");

	property p_high_write_copy;
		@(posedge aclk) disable iff (!aresetn)
		wr_fire && wr_lane0 && aw_addr_reg == ADDR_CMPA_HI
			|=> compare_a_value_reg == {$past(wbyte), $past(hold_reg)};
	endproperty
	a_high_write_copy: assert property (p_high_write_copy) else $error("high write copy wrong");

	property p_high_read_capture;
		@(posedge aclk) disable iff (!aresetn)
		rd_fire && s_axi_araddr == ADDR_CMPA_HI && !wr_fire |=> hold_reg == $past(compare_a_value_reg[7:0]);
	endproperty
	a_high_read_capture: assert property (p_high_read_capture) else $error("capture wrong");

	property p_low_read_buffer;
		@(posedge aclk) disable iff (!aresetn)
		rd_fire && s_axi_araddr == ADDR_CNT_LO |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(hold_reg);
	endproperty
	a_low_read_buffer: assert property (p_low_read_buffer) else $error("low read not buffer");

	property p_cmp_high;
		@(posedge aclk) disable iff (!aresetn)
		running && tick && match_a && ctrl1_reg.mode == MODE_CMP_OUT && ctrl1_reg.ofunc == OF_HIGH
			|=> timer_wave_out;
	endproperty
	a_cmp_high: assert property (p_cmp_high) else $error("output not set high");

	c_match_a: cover property (@(posedge aclk) disable iff (!aresetn) running && tick && match_a);
	c_ovf: cover property (@(posedge aclk) disable iff (!aresetn) running && tick && ovf);
	c_ext: cover property (@(posedge aclk) disable iff (!aresetn) running && ext_rise && ext_sel);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq && ext_fall == 1'b0);
endmodule
`default_nettype wire

//--- tb/tmc_far_end.sv
// far-side model: count pin driver, clock-enable sources, output pin load
`timescale 1ns/10ps
`default_nettype none
module tmc_far_end (
	// clock
	input wire logic aclk,
	// output pin and its load
	input wire logic timer_wave_out,
	input wire logic timer_wave_oe,
	output logic pin_level,
	// sources
	output logic timer_ext_clock_in,
	output logic high_clk_en,
	output logic sub_clk_en
);
	logic [2:0] ph;
	initial begin
		timer_ext_clock_in = 1'b0;
		ph = 3'h0;
	end
	// weak pull-down while the pin is not driven
	assign pin_level = timer_wave_oe ? timer_wave_out : 1'b0;
	// high clock every 2nd cycle, sub clock every 8th
	assign high_clk_en = ph[0];
	assign sub_clk_en = (ph == 3'h7);
	always @(posedge aclk) ph <= ph + 3'h1;
	// pulse train, gap cycles per level, slow or prompt
	task automatic ext_burst(input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			timer_ext_clock_in <= 1'b1;
			repeat (gap) @(posedge aclk);
			timer_ext_clock_in <= 1'b0;
			repeat (gap - 1) @(posedge aclk);
		end
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench of the timer core
`timescale 1ns/10ps
`default_nettype none
module tb import tmc_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic high_clk_en, sub_clk_en, timer_ext_clock_in, timer_wave_out, timer_wave_oe, pulse_trigger, irq, pin_level;
	logic [15:0] v;
	logic [5:0] ra [4] = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_IRQ_STAT, ADDR_IRQ_EN};
	int n_errors = 0, checks = 0, n_trig = 0, h, n, i0;

	always #2.5 aclk = ~aclk;
	always @(posedge aclk) if (pulse_trigger === 1'b1) n_trig = n_trig + 1;

	tmc_core #(.CNT_W(16)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_clk_en,
		.sub_clk_en, .timer_ext_clock_in, .timer_wave_out, .timer_wave_oe, .pulse_trigger, .irq);
	tmc_far_end far (.aclk, .timer_wave_out, .timer_wave_oe, .pin_level, .timer_ext_clock_in, .high_clk_en,
		.sub_clk_en);

	// ----------------------------------------
	// bus tasks, compares, expectations
	// ----------------------------------------
	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp=%h got=%h", nm, e, g);
		end
	endtask
	task automatic chk_near(input string nm, input int e, input int tol, input logic [31:0] g);
		checks++;
		if ($isunknown(g) || int'(g) > e + tol || int'(g) < e - tol) begin
			n_errors++;
			$display("[ERR] %s exp=%0d got=%0d", nm, e, g);
		end
	endtask
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
	endtask
	task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic wr16(input logic [5:0] lo, input logic [15:0] d);
		axi_wr(lo, {24'h000000, d[7:0]}, rr);
		axi_wr(lo + 6'h04, {24'h000000, d[15:8]}, rr);
	endtask
	task automatic rd16(input logic [5:0] lo, output logic [15:0] d);
		axi_rd(lo + 6'h04, rv, rr);
		d[15:8] = rv[7:0];
		axi_rd(lo, rv, rr);
		d[7:0] = rv[7:0];
	endtask
	function automatic logic [31:0] f_c1(input logic [1:0] m, input logic [1:0] o, input logic i, input logic p);
		return {24'h000000, m, o, i, 2'b00, p};
	endfunction
	function automatic logic [31:0] f_c0(input int sel, input logic on);
		return {24'h000000, 1'b0, 3'(sel), on, 3'b000};
	endfunction
	function automatic int f_cnt(input int sel, input int w);
		case (sel)
			0: return w / 4;
			1: return w;
			2: return w / 32;
			3: return w / 128;
			default: return w / 8;
		endcase
	endfunction
	function automatic logic f_wave(input int of, input logic init);
		case (of)
			0: return init;
			1: return 1'b0;
			2: return 1'b1;
			default: return !init;
		endcase
	endfunction
	task automatic summarize();
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge aclk);
		n_errors++;
		$display("[ERR] watchdog exp=done got=hang");
		summarize();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		void'($urandom(32'hEF29));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_val("irq_rst", 32'h0, irq);
		chk_val("oe_rst", 32'h0, timer_wave_oe);
		foreach (ra[k]) begin
			axi_rd(ra[k], rv, rr);
			chk_val("reg_rst", 32'h0, rv);
		end
		axi_rd(6'h2C, rv, rr);
		chk_val("unmapped_rd", {30'h0, RESP_SLVERR}, {30'h0, rr});
		chk_val("unmapped_data", 32'h0, rv);
		axi_wr(6'h2C, 32'hFF, rr);
		chk_val("unmapped_wr", {30'h0, RESP_SLVERR}, {30'h0, rr});
		axi_wr(ADDR_CTRL1, 32'hFF, rr);
		axi_rd(ADDR_CTRL1, rv, rr);
		chk_val("ctrl1_bits", {24'h0, CTRL1_MASK}, rv);
		$display("test regs done");
		for (int k = 0; k < 2; k++) begin
			i0 = k ? ADDR_CMPP_LO : ADDR_CMPA_LO;
			h = 16'($urandom);
			wr16(6'(i0), 16'(h));
			rd16(6'(i0), v);
			chk_val("cmp_pair", 32'(h), 32'(v));
			axi_wr(6'(i0), {24'h0, ~v[7:0]}, rr);
			rd16(6'(i0), v);
			chk_val("cmp_low_only", 32'(h), 32'(v));
		end
		wr16(ADDR_CMPA_LO, 16'hA55A);
		rd16(ADDR_CMPA_LO, v);
		chk_val("cmp_a_back", 32'hA55A, 32'(v));
		$display("test pairs done");
		wr16(ADDR_CMPA_LO, 16'hFFFF);
		wr16(ADDR_CMPP_LO, 16'h0100);
		axi_wr(ADDR_CTRL1, f_c1(MODE_TIMER, 2'h0, 1'b0, 1'b1), rr);
		axi_wr(ADDR_CTRL0, f_c0(1, 1'b1), rr);
		repeat (600) @(posedge aclk);
		chk_val("oe_timer", 32'h0, timer_wave_oe);
		rd16(ADDR_CNT_LO, v);
		chk_near("cnt_pclr", 128, 128, 32'(v));
		axi_rd(ADDR_IRQ_STAT, rv, rr);
		chk_val("stat_p", 32'h2, rv);
		chk_val("irq_off", 32'h0, irq);
		axi_wr(ADDR_IRQ_EN, 32'h1, rr);
		chk_val("irq_masked", 32'h0, irq);
		axi_wr(ADDR_IRQ_EN, 32'h2, rr);
		chk_val("irq_on", 32'h1, irq);
		axi_wr(ADDR_CTRL0, f_c0(1, 1'b0), rr);
		axi_wr(ADDR_IRQ_CLR, 32'h2, rr);
		axi_rd(ADDR_IRQ_STAT, rv, rr);
		chk_val("stat_clr", 32'h0, rv);
		chk_val("irq_clr", 32'h0, irq);
		wr16(ADDR_CMPA_LO, 16'h0100);
		wr16(ADDR_CMPP_LO, 16'h8000);
		axi_wr(ADDR_CTRL1, f_c1(MODE_TIMER, 2'h0, 1'b0, 1'b0), rr);
		axi_wr(ADDR_CTRL0, f_c0(1, 1'b1), rr);
		repeat (600) @(posedge aclk);
		axi_wr(ADDR_CTRL0, f_c0(1, 1'b0), rr);
		axi_rd(ADDR_IRQ_STAT, rv, rr);
		chk_val("stat_a", 32'h1, rv);
		axi_wr(ADDR_IRQ_CLR, 32'h7, rr);
		$display("test irq done");
		wr16(ADDR_CMPA_LO, 16'hFFFF);
		for (int s = 0; s < 6; s++) begin
			axi_wr(ADDR_CTRL0, f_c0(s, 1'b1), rr);
			repeat (1024) @(posedge aclk);
			axi_wr(ADDR_CTRL0, f_c0(s, 1'b0), rr);
			rd16(ADDR_CNT_LO, v);
			chk_near("cnt_sel", f_cnt(s, 1024), 4, 32'(v));
		end
		axi_wr(ADDR_CTRL0, f_c0(1, 1'b1) | 32'(1 << CTRL0_PAUSE), rr);
		repeat (100) @(posedge aclk);
		axi_wr(ADDR_CTRL0, f_c0(1, 1'b0), rr);
		rd16(ADDR_CNT_LO, v);
		chk_val("cnt_pause", 32'h0, 32'(v));
		for (int s = 6; s < 8; s++) begin
			axi_wr(ADDR_CTRL0, f_c0(s, 1'b1), rr);
			n = $urandom_range(20, 1);
			n_trig = 0;
			far.ext_burst(n, $urandom_range(12, 3));
			repeat (8) @(posedge aclk);
			axi_wr(ADDR_CTRL0, f_c0(s, 1'b0), rr);
			rd16(ADDR_CNT_LO, v);
			chk_val("cnt_ext", 32'(n), 32'(v));
			chk_val("trig_ext", 32'(n), 32'(n_trig));
		end
		$display("test clocks done");
		wr16(ADDR_CMPA_LO, 16'h0040);
		for (int of = 0; of < 4; of++) begin
			h = $urandom_range(1, 0);
			axi_wr(ADDR_CTRL1, f_c1(MODE_CMP_OUT, 2'(of), 1'(h), 1'b0), rr);
			axi_rd(ADDR_CTRL1, rv, rr);
			chk_val("ctrl1_rd", f_c1(MODE_CMP_OUT, 2'(of), 1'(h), 1'b0), rv);
			axi_wr(ADDR_CTRL0, f_c0(1, 1'b1), rr);
			repeat (20) @(posedge aclk);
			chk_val("wave_init", 32'(h), 32'(pin_level));
			repeat (80) @(posedge aclk);
			chk_val("wave_match", 32'(f_wave(of, 1'(h))), 32'(pin_level));
			axi_wr(ADDR_CTRL0, f_c0(1, 1'b0), rr);
		end
		n = $urandom_range(128, 32);
		wr16(ADDR_CMPA_LO, 16'(n));
		wr16(ADDR_CMPP_LO, 16'h0100);
		for (int of = 0; of < 3; of++) begin
			axi_wr(ADDR_CTRL1, f_c1(MODE_PWM, 2'(of), 1'b1, 1'b1), rr);
			axi_wr(ADDR_CTRL0, f_c0(1, 1'b1), rr);
			h = 0;
			repeat (514) begin
				@(posedge aclk);
				h += int'(pin_level === 1'b1);
			end
			chk_near("pwm_high", (of == 0) ? 0 : (of == 1) ? 514 : 2 * n, 6, 32'(h));
			axi_wr(ADDR_CTRL0, f_c0(1, 1'b0), rr);
		end
		$display("test wave done");
		summarize();
	end
endmodule
`default_nettype wire
